// [inc/aakp_defs.svh]
// Purpose: constants for the alarm annunciator key panel
// Assumes: ref_clk at 25 MHz; register offsets are byte addresses of 32-bit words
`ifndef AAKP_DEFS_SVH
`define AAKP_DEFS_SVH

`define AAKP_CLK_HZ 25000000
`define AAKP_SIL_LOCK_S 10
`define AAKP_MENU_IDLE_S 60
`define AAKP_BLINK_HALF_MS 500
`define AAKP_CNT_W 8

// register byte offsets
`define AAKP_REG_CTRL 8'h00
`define AAKP_REG_STATUS 8'h04
`define AAKP_REG_ALARM_CNT 8'h08
`define AAKP_REG_PRE_CNT 8'h0c
`define AAKP_REG_TRB_CNT 8'h10
`define AAKP_REG_SUP_CNT 8'h14
`define AAKP_REG_MENU 8'h18

// control register fields
`define AAKP_CTRL_PANEL_EN 0
`define AAKP_CTRL_SOUNDER_EN 1
`define AAKP_CTRL_RESET_VAL 32'h0000_0003

// status register fields
`define AAKP_ST_OFF_NORMAL 0
`define AAKP_ST_MENU 1
`define AAKP_ST_SILENCED 2
`define AAKP_ST_SIL_LOCK 3
`define AAKP_ST_SOUNDER 4
`define AAKP_ST_AC_OK 5

`endif

// [inc/aakp_pkg.sv]
// Purpose: types for the alarm annunciator key panel
// Assumes: nothing beyond the defs header
// Notes: key codes and category indices shared by the panel and the testbench modules
package aakp_pkg;
    typedef enum logic [3:0] {
        AAKP_KEY_NONE = 4'b0000,
        AAKP_KEY_ACK = 4'b0001,
        AAKP_KEY_SILENCE = 4'b0010,
        AAKP_KEY_RESET = 4'b0011,
        AAKP_KEY_SCROLL = 4'b0100,
        AAKP_KEY_DIGIT = 4'b0101,
        AAKP_KEY_BACKSPACE = 4'b0110,
        AAKP_KEY_ENTER = 4'b0111
    } aakp_key_t;

    typedef enum logic [1:0] {
        AAKP_MODE_NORMAL = 2'b00,
        AAKP_MODE_OFF_NORMAL = 2'b01,
        AAKP_MODE_MENU = 2'b10
    } aakp_mode_t;

    typedef enum logic [1:0] {
        AAKP_CAT_ALARM = 2'b00,
        AAKP_CAT_PRE = 2'b01,
        AAKP_CAT_TRB = 2'b10,
        AAKP_CAT_SUP = 2'b11
    } aakp_cat_t;
endpackage : aakp_pkg

// [hw/aakp_led_cat.sv]
// Purpose: one category indicator driven by its event counts
// Assumes: blink is the shared phase from the panel
// Notes: dark only when no active and no unacknowledged events remain
`timescale 1ns/1ps
`default_nettype none
module aakp_led_cat (
    input wire logic [7:0] unack_cnt,
    input wire logic [7:0] active_cnt,
    input wire logic hold,
    input wire logic blink,
    output logic led
);
    // flashing beats steady; hold keeps a steady lamp until cleared elsewhere
    always_comb
    begin
        if (unack_cnt != 8'h00)
            led = blink;
        else if (active_cnt != 8'h00 || hold)
            led = 1'b1;
        else
            led = 1'b0;
    end
endmodule : aakp_led_cat
`default_nettype wire

// [hw/aakp_panel.sv]
// Purpose: key decode, indicator and silence logic of the alarm annunciator panel
// Assumes: key_valid and events come from logic on ref_clk; ac_ok_pin is a raw pin
// Notes: registers on Avalon-MM, one wait cycle on every access
`timescale 1ns/1ps
`default_nettype none
`include "aakp_defs.svh"
module aakp_panel #(
    parameter int unsigned SIL_LOCK_CYCLES = `AAKP_CLK_HZ * `AAKP_SIL_LOCK_S,
    parameter int unsigned MENU_IDLE_CYCLES = `AAKP_CLK_HZ * `AAKP_MENU_IDLE_S,
    parameter int unsigned BLINK_HALF_CYCLES = (`AAKP_CLK_HZ / 1000) * `AAKP_BLINK_HALF_MS
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic key_valid,
    input wire aakp_pkg::aakp_key_t key_code,
    input wire logic [3:0] key_digit,
    input wire logic [3:0] ev_new,
    input wire logic [3:0] ev_clear,
    input wire logic alarm_off_rpt,
    input wire logic [1:0] disp_cat,
    input wire logic ac_ok_pin,
    output logic ocp_start,
    output logic public_notify,
    output logic silenceable_on,
    output logic sounder,
    output logic led_power,
    output logic led_alarm,
    output logic led_pre,
    output logic led_trouble,
    output logic led_super,
    output logic led_silence,
    output logic scroll_step,
    output logic menu_active,
    output logic [3:0] digit_out,
    output logic digit_strobe,
    output logic enter_strobe,
    output logic erase_strobe,
    input wire logic [7:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest
);
    import aakp_pkg::*;

    logic [7:0] unack_reg [4];
    logic [7:0] active_reg [4];
    logic alarm_off_pend_reg;
    logic alarm_hold_reg;
    aakp_mode_t mode_reg;
    logic silenced_reg;
    logic sil_used_reg;
    logic [31:0] sil_lock_reg;
    logic [31:0] idle_reg;
    logic [31:0] blink_cnt_reg;
    logic blink_reg;
    logic [31:0] ctrl_reg;
    logic ac_meta_reg;
    logic ac_sync_reg;
    logic ack_done_reg;
    logic key_ack, key_sil, key_rst, key_scr, key_dig, key_bsp, key_ent;
    logic all_alarm_ack;
    logic sil_accept;
    logic rst_accept;
    logic any_event;
    logic panel_en;
    logic bus_req;

    // saturating step of an event count
    function automatic logic [7:0] cnt_step(input logic [7:0] c, input logic inc, input logic dec);
        logic [7:0] r;
        r = c;
        if (inc && !dec && c != 8'hff)
            r = c + 8'h01;
        else if (dec && !inc && c != 8'h00)
            r = c - 8'h01;
        cnt_step = r;
    endfunction : cnt_step

    // key decode, qualified by the software enable
    assign panel_en = ctrl_reg[`AAKP_CTRL_PANEL_EN];
    always_comb
    begin
        key_ack = key_valid && panel_en && key_code == AAKP_KEY_ACK;
        key_sil = key_valid && panel_en && key_code == AAKP_KEY_SILENCE;
        key_rst = key_valid && panel_en && key_code == AAKP_KEY_RESET;
        key_scr = key_valid && panel_en && key_code == AAKP_KEY_SCROLL;
        key_dig = key_valid && panel_en && key_code == AAKP_KEY_DIGIT && key_digit <= 4'h9;
        key_bsp = key_valid && panel_en && key_code == AAKP_KEY_BACKSPACE;
        key_ent = key_valid && panel_en && key_code == AAKP_KEY_ENTER;
    end

    assign all_alarm_ack = (unack_reg[AAKP_CAT_ALARM] == 8'h00) && !alarm_off_pend_reg;
    assign sil_accept = key_sil && all_alarm_ack && sil_lock_reg == 32'h0;
    assign rst_accept = key_rst && all_alarm_ack && active_reg[AAKP_CAT_ALARM] == 8'h00;
    assign any_event = (active_reg[0] | active_reg[1] | active_reg[2] | active_reg[3]
        | unack_reg[0] | unack_reg[1] | unack_reg[2] | unack_reg[3]) != 8'h00;

    // ac supervisor pin is asynchronous: two flops before use
    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            ac_meta_reg <= 1'b0;
            ac_sync_reg <= 1'b0;
        end
        else
        begin
            ac_meta_reg <= ac_ok_pin;
            ac_sync_reg <= ac_meta_reg;
        end
    end

    // event counts; acknowledge clears the displayed category, a new event still counts
    always_ff @(posedge ref_clk)
    begin
        for (int i = 0; i < 4; i++)
        begin
            if (rst)
            begin
                unack_reg[i] <= 8'h00;
                active_reg[i] <= 8'h00;
            end
            else
            begin
                active_reg[i] <= cnt_step(active_reg[i], ev_new[i], ev_clear[i]);
                if (key_ack && disp_cat == 2'(i))
                    unack_reg[i] <= {7'h00, ev_new[i]};
                else
                    unack_reg[i] <= cnt_step(unack_reg[i], ev_new[i], 1'b0);
            end
        end
    end

    // alarm-off reports need their own acknowledgement; a report beats the clear
    always_ff @(posedge ref_clk)
    begin
        if (rst)
            alarm_off_pend_reg <= 1'b0;
        else if (alarm_off_rpt)
            alarm_off_pend_reg <= 1'b1;
        else if (key_ack && disp_cat == AAKP_CAT_ALARM)
            alarm_off_pend_reg <= 1'b0;
    end

    // alarm lamp stays steady after sources clear until an accepted reset
    always_ff @(posedge ref_clk)
    begin
        if (rst)
            alarm_hold_reg <= 1'b0;
        else if (ev_new[AAKP_CAT_ALARM])
            alarm_hold_reg <= 1'b1;
        else if (rst_accept)
            alarm_hold_reg <= 1'b0;
    end

    // operating mode
    always_ff @(posedge ref_clk)
    begin
        if (rst)
            mode_reg <= AAKP_MODE_NORMAL;
        else
        begin
            case (mode_reg)
                AAKP_MODE_NORMAL:
                begin
                    if (any_event || ev_new != 4'h0)
                        mode_reg <= AAKP_MODE_OFF_NORMAL;
                    else if (key_dig && key_digit == 4'h0)
                        mode_reg <= AAKP_MODE_MENU;
                end
                AAKP_MODE_OFF_NORMAL:
                begin
                    if (rst_accept && !any_event && !alarm_hold_reg)
                        mode_reg <= AAKP_MODE_NORMAL;
                    else if (rst_accept && unack_reg[1] == 8'h00 && unack_reg[2] == 8'h00
                        && unack_reg[3] == 8'h00 && active_reg[1] == 8'h00
                        && active_reg[2] == 8'h00 && active_reg[3] == 8'h00)
                        mode_reg <= AAKP_MODE_NORMAL;
                end
                AAKP_MODE_MENU:
                begin
                    if (ev_new[AAKP_CAT_ALARM] || key_bsp || idle_reg == 32'h1)
                        mode_reg <= any_event ? AAKP_MODE_OFF_NORMAL : AAKP_MODE_NORMAL;
                end
                default:
                    mode_reg <= AAKP_MODE_NORMAL;
            endcase
        end
    end

    // one-cycle start of the output program, raised with the step out of normal;
    // keyed to the step from normal to off-normal only; a direct exit from the menu raises none
    always_ff @(posedge ref_clk)
    begin
        if (rst)
            ocp_start <= 1'b0;
        else
            ocp_start <= mode_reg == AAKP_MODE_NORMAL && (any_event || ev_new != 4'h0);
    end

    // menu idle timer restarts on every key
    always_ff @(posedge ref_clk)
    begin
        if (rst || mode_reg != AAKP_MODE_MENU)
            idle_reg <= MENU_IDLE_CYCLES;
        else if (key_valid)
            idle_reg <= MENU_IDLE_CYCLES;
        else if (idle_reg > 32'h1)
            idle_reg <= idle_reg - 32'h1;
    end

    // silence lockout counts from each accepted press
    always_ff @(posedge ref_clk)
    begin
        if (rst)
            sil_lock_reg <= 32'h0;
        else if (sil_accept)
            sil_lock_reg <= SIL_LOCK_CYCLES;
        else if (sil_lock_reg != 32'h0)
            sil_lock_reg <= sil_lock_reg - 32'h1;
    end

    // silence toggle; an accepted reset clears it, new alarms re-sound
    always_ff @(posedge ref_clk)
    begin
        if (rst || rst_accept)
        begin
            silenced_reg <= 1'b0;
            sil_used_reg <= 1'b0;
        end
        else if (sil_accept)
        begin
            silenced_reg <= !silenced_reg;
            sil_used_reg <= 1'b1;
        end
        else if (ev_new[AAKP_CAT_ALARM])
            silenced_reg <= 1'b0;
    end

    // shared blink phase so every lamp flashes together
    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            blink_cnt_reg <= 32'h0;
            blink_reg <= 1'b0;
        end
        else if (blink_cnt_reg >= BLINK_HALF_CYCLES - 1)
        begin
            blink_cnt_reg <= 32'h0;
            blink_reg <= !blink_reg;
        end
        else
            blink_cnt_reg <= blink_cnt_reg + 32'h1;
    end

    // outputs from flops
    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            public_notify <= 1'b0;
            silenceable_on <= 1'b0;
            sounder <= 1'b0;
            led_power <= 1'b0;
            led_silence <= 1'b0;
            ack_done_reg <= 1'b0;
        end
        else
        begin
            public_notify <= active_reg[AAKP_CAT_ALARM] != 8'h00 || alarm_hold_reg;
            silenceable_on <= (active_reg[AAKP_CAT_ALARM] != 8'h00 || alarm_hold_reg) && !silenced_reg;
            ack_done_reg <= (unack_reg[0] | unack_reg[1] | unack_reg[2] | unack_reg[3]) == 8'h00
                && !alarm_off_pend_reg;
            sounder <= !ack_done_reg && ctrl_reg[`AAKP_CTRL_SOUNDER_EN];
            led_power <= ac_sync_reg;
            led_silence <= silenced_reg;
        end
    end

    // menu and display strobes
    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            scroll_step <= 1'b0;
            digit_strobe <= 1'b0;
            digit_out <= 4'h0;
            enter_strobe <= 1'b0;
            erase_strobe <= 1'b0;
        end
        else
        begin
            scroll_step <= key_scr;
            digit_strobe <= key_dig;
            if (key_dig)
                digit_out <= key_digit;
            enter_strobe <= key_ent && mode_reg == AAKP_MODE_MENU;
            erase_strobe <= key_bsp;
        end
    end
    assign menu_active = mode_reg == AAKP_MODE_MENU;

    // category lamps
    aakp_led_cat u_alarm (
        .unack_cnt(alarm_off_pend_reg ? 8'h01 : unack_reg[AAKP_CAT_ALARM]),
        .active_cnt(active_reg[AAKP_CAT_ALARM]),
        .hold(alarm_hold_reg),
        .blink(blink_reg),
        .led(led_alarm)
    );
    aakp_led_cat u_pre (
        .unack_cnt(unack_reg[AAKP_CAT_PRE]),
        .active_cnt(active_reg[AAKP_CAT_PRE]),
        .hold(1'b0),
        .blink(blink_reg),
        .led(led_pre)
    );
    aakp_led_cat u_trb (
        .unack_cnt(unack_reg[AAKP_CAT_TRB]),
        .active_cnt(active_reg[AAKP_CAT_TRB]),
        .hold(1'b0),
        .blink(blink_reg),
        .led(led_trouble)
    );
    aakp_led_cat u_sup (
        .unack_cnt(unack_reg[AAKP_CAT_SUP]),
        .active_cnt(active_reg[AAKP_CAT_SUP]),
        .hold(1'b0),
        .blink(blink_reg),
        .led(led_super)
    );

    // avalon slave: waitrequest high in the first cycle of every access
    assign bus_req = avs_read || avs_write;
    logic bus_ack_reg;
    always_ff @(posedge ref_clk)
    begin
        if (rst)
            bus_ack_reg <= 1'b0;
        else
            bus_ack_reg <= bus_req && !bus_ack_reg;
    end
    assign avs_waitrequest = bus_req && !bus_ack_reg;

    // control register write
    always_ff @(posedge ref_clk)
    begin
        if (rst)
            ctrl_reg <= `AAKP_CTRL_RESET_VAL;
        else if (avs_write && bus_ack_reg && avs_address == `AAKP_REG_CTRL)
            ctrl_reg <= {30'h0, avs_writedata[1:0]};
    end

    // read data; unmapped addresses read zero
    always_ff @(posedge ref_clk)
    begin
        if (rst)
            avs_readdata <= 32'h0;
        else if (avs_read && !bus_ack_reg)
        begin
            case (avs_address)
                `AAKP_REG_CTRL: avs_readdata <= ctrl_reg;
                `AAKP_REG_STATUS: avs_readdata <= {26'h0, ac_sync_reg, sounder, sil_lock_reg != 32'h0,
                    silenced_reg, menu_active, mode_reg != AAKP_MODE_NORMAL};
                `AAKP_REG_ALARM_CNT: avs_readdata <= {16'h0, unack_reg[0], active_reg[0]};
                `AAKP_REG_PRE_CNT: avs_readdata <= {16'h0, unack_reg[1], active_reg[1]};
                `AAKP_REG_TRB_CNT: avs_readdata <= {16'h0, unack_reg[2], active_reg[2]};
                `AAKP_REG_SUP_CNT: avs_readdata <= {16'h0, unack_reg[3], active_reg[3]};
                `AAKP_REG_MENU: avs_readdata <= {28'h0, digit_out};
                default: avs_readdata <= 32'h0;
            endcase
        end
    end
endmodule : aakp_panel
`default_nettype wire

// [testbench/aakp_operator.sv]
// Purpose: keypad operator model for the key panel
// Assumes: one key press is a one-cycle pulse on ref_clk
// Notes: gap lets the operator press promptly or slowly
`timescale 1ns/1ps
`default_nettype none
module aakp_operator (
    input wire logic ref_clk,
    output logic key_valid,
    output aakp_pkg::aakp_key_t key_code,
    output logic [3:0] key_digit
);
    import aakp_pkg::*;

    // keypad idle at time zero
    initial
    begin
        key_valid = 1'b0;
        key_code = AAKP_KEY_NONE;
        key_digit = 4'h0;
    end

    // digit lines flip on release so a stale value never looks valid
    task press(input aakp_key_t c, input logic [3:0] d, input int gap);
        repeat (gap) @(posedge ref_clk);
        @(posedge ref_clk);
        key_valid <= 1'b1;
        key_code <= c;
        key_digit <= d;
        @(posedge ref_clk);
        key_valid <= 1'b0;
        key_code <= AAKP_KEY_NONE;
        key_digit <= ~d;
    endtask : press
endmodule : aakp_operator
`default_nettype wire

// [testbench/aakp_panel_checker.sv]
// Purpose: port assertions for the key panel
// Assumes: keys and events arrive on ref_clk
// Notes: bound to every panel instance
`timescale 1ns/1ps
`default_nettype none
module aakp_panel_checker (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic key_valid,
    input wire aakp_pkg::aakp_key_t key_code,
    input wire logic [3:0] key_digit,
    input wire logic [3:0] ev_new,
    input wire logic ac_ok_pin,
    input wire logic ocp_start,
    input wire logic public_notify,
    input wire logic silenceable_on,
    input wire logic led_power,
    input wire logic led_silence,
    input wire logic scroll_step,
    input wire logic menu_active,
    input wire logic [3:0] digit_out,
    input wire logic digit_strobe,
    input wire logic erase_strobe
);
    import aakp_pkg::*;
    logic sil_key;

    // silence press decoded once for the indicator check
    assign sil_key = key_valid && key_code == AAKP_KEY_SILENCE;
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);

    ocp_pulse_a:
        assert property (ocp_start |=> !ocp_start)
        else $error("program start wider than one cycle");
    alarm_notify_a:
        assert property (ev_new[0] |-> ##[1:3] public_notify)
        else $error("alarm not announced");
    silence_gate_a:
        assert property (silenceable_on == (public_notify && !led_silence))
        else $error("silenceable outputs disagree with notification or silence state");
    power_led_a:
        assert property (led_power |-> $past(ac_ok_pin, 3))
        else $error("power lit without good supply");
    silence_led_a:
        assert property ($rose(led_silence) |-> $past(sil_key) || $past(sil_key, 2))
        else $error("silence lit without a silence press");
    scroll_key_a:
        assert property (scroll_step |-> $past(key_valid && key_code == AAKP_KEY_SCROLL))
        else $error("scroll step without scroll press");
    digit_key_a:
        assert property (digit_strobe |-> $past(key_valid && key_code == AAKP_KEY_DIGIT
            && key_digit <= 4'h9) && digit_out == $past(key_digit))
        else $error("digit strobe wrong");
    erase_key_a:
        assert property (erase_strobe |-> $past(key_valid && key_code == AAKP_KEY_BACKSPACE))
        else $error("erase without backspace");
    menu_alarm_a:
        assert property (menu_active && ev_new[0] |-> ##[1:3] !menu_active)
        else $error("menu kept through alarm");
endmodule : aakp_panel_checker

bind aakp_panel aakp_panel_checker chk_i (.ref_clk, .rst, .key_valid, .key_code, .key_digit,
    .ev_new, .ac_ok_pin, .ocp_start, .public_notify, .silenceable_on, .led_power,
    .led_silence, .scroll_step, .menu_active, .digit_out, .digit_strobe, .erase_strobe);
`default_nettype wire

// [testbench/aakp_panel_tb_top.sv]
// Purpose: self-checking bench for the key panel
// Assumes: shortened lockout 50, idle 100, blink half 4
// Notes: counts model kept in integer arrays
`timescale 1ns/1ps
`default_nettype none
module aakp_panel_tb_top;
    import aakp_pkg::*;
    logic ref_clk, rst, key_valid, alarm_off_rpt, ac_ok_pin, avs_read, avs_write;
    aakp_key_t key_code;
    logic [3:0] key_digit, ev_new, ev_clear, digit_out, dg;
    logic [1:0] disp_cat;
    logic ocp_start, public_notify, silenceable_on, sounder, led_power, led_alarm;
    logic led_pre, led_trouble, led_super, led_silence, scroll_step, menu_active;
    logic digit_strobe, enter_strobe, erase_strobe, avs_waitrequest;
    logic [7:0] avs_address;
    logic [31:0] avs_writedata, avs_readdata, d;
    int errors, check_count, ocp_n, hi, act[4], una[4];

    aakp_panel #(.SIL_LOCK_CYCLES(50), .MENU_IDLE_CYCLES(100), .BLINK_HALF_CYCLES(4)) DUT (
        .ref_clk, .rst, .key_valid, .key_code, .key_digit, .ev_new, .ev_clear,
        .alarm_off_rpt, .disp_cat, .ac_ok_pin, .ocp_start, .public_notify, .silenceable_on,
        .sounder, .led_power, .led_alarm, .led_pre, .led_trouble, .led_super, .led_silence,
        .scroll_step, .menu_active, .digit_out, .digit_strobe, .enter_strobe, .erase_strobe,
        .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_readdata, .avs_waitrequest);
    aakp_operator op (.ref_clk, .key_valid, .key_code, .key_digit);

    // 25 MHz clock
    initial
    begin
        ref_clk = 1'b0;
        forever #20 ref_clk = ~ref_clk;
    end

    // program start pulses counted as they happen
    always @(posedge ref_clk) if (ocp_start === 1'b1) ocp_n++;

    // watchdog well beyond the few hundred cycles of the run
    initial
    begin
        repeat (20000) @(posedge ref_clk);
        errors++;
        report_and_stop();
    end

    task report_and_stop;
        $display("errors=%0d checks=%0d", errors, check_count);
        if (errors == 0 && check_count > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : report_and_stop

    task chk(input logic [31:0] s, input logic [31:0] e);
        check_count++;
        if (s !== e)
        begin
            errors++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask : chk

    // request held until waitrequest is seen low at an edge
    task bus(input logic we, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd);
        int n;
        n = 0;
        @(posedge ref_clk);
        avs_address <= a;
        avs_write <= we;
        avs_read <= !we;
        avs_writedata <= wd;
        do
        begin
            @(posedge ref_clk);
            n++;
        end
        while (avs_waitrequest !== 1'b0 && n < 50);
        rd = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        if (n >= 50) errors++;
    endtask : bus

    task ev(input int c, input bit clr);
        @(posedge ref_clk);
        ev_new[c] <= !clr;
        ev_clear[c] <= clr;
        @(posedge ref_clk);
        ev_new <= 4'h0;
        ev_clear <= 4'h0;
        act[c] += clr ? -1 : 1;
        una[c] += clr ? 0 : 1;
    endtask : ev

    task chk_cnt;
        for (int c = 0; c < 4; c++)
        begin
            bus(1'b0, 8'(8 + 4 * c), 32'h0, d);
            chk(d, {16'h0, 8'(una[c]), 8'(act[c])});
        end
    endtask : chk_cnt

    // counts lit cycles; optionally compares phase with pre-alarm
    task blink(input bit ph);
        hi = 0;
        repeat (12)
        begin
            @(posedge ref_clk);
            #1;
            hi += led_alarm;
            if (ph) chk(led_pre, led_alarm);
        end
    endtask : blink

    task key(input aakp_key_t c, input logic [3:0] v);
        op.press(c, v, 1);
        #1;
    endtask : key

    initial
    begin
        void'($urandom(47216));
        {rst, ac_ok_pin} = 2'b11;
        {alarm_off_rpt, avs_read, avs_write} = 3'b000;
        {ev_new, ev_clear, disp_cat, avs_address, avs_writedata} = '0;
        repeat (3) @(posedge ref_clk);
        rst <= 1'b0;
        repeat (4) @(posedge ref_clk);
        chk(led_power, 1);
        bus(1'b1, 8'h40, 32'hffff_ffff, d);
        bus(1'b0, 8'h40, 32'h0, d);
        chk(d, 32'h0);
        bus(1'b0, 8'h04, 32'h0, d);
        chk(d[0], 0);
        // menu keys while normal
        key(AAKP_KEY_DIGIT, 4'h0);
        chk(menu_active, 1);
        repeat (4)
        begin
            dg = 4'($urandom_range(9, 0));
            op.press(AAKP_KEY_DIGIT, dg, $urandom_range(3, 0));
            #1;
            chk({digit_strobe, digit_out}, {1'b1, dg});
        end
        bus(1'b0, 8'h18, 32'h0, d);
        chk(d, {28'h0, dg});
        key(AAKP_KEY_DIGIT, 4'hc);
        chk(digit_strobe, 0);
        key(AAKP_KEY_SCROLL, 4'h0);
        chk(scroll_step, 1);
        key(AAKP_KEY_ENTER, 4'h0);
        chk(enter_strobe, 1);
        key(AAKP_KEY_BACKSPACE, 4'h0);
        chk({erase_strobe, menu_active}, 2'b10);
        key(AAKP_KEY_DIGIT, 4'h0);
        repeat (90) @(posedge ref_clk);
        chk(menu_active, 1);
        repeat (20) @(posedge ref_clk);
        chk(menu_active, 0);
        key(AAKP_KEY_DIGIT, 4'h0);
        // alarm plus random other events
        ev(0, 0);
        repeat (3) @(posedge ref_clk);
        chk(menu_active, 0);
        for (int c = 1; c < 4; c++) repeat ($urandom_range(3, 1)) ev(c, 0);
        chk(ocp_n, 1);
        chk(public_notify, 1);
        chk_cnt();
        blink(1'b1);
        chk(hi > 0 && hi < 12, 1);
        chk(sounder, 1);
        key(AAKP_KEY_SILENCE, 4'h0);
        repeat (2) @(posedge ref_clk);
        chk({silenceable_on, led_silence}, 2'b10);
        for (int c = 0; c < 4; c++)
        begin
            @(posedge ref_clk);
            disp_cat <= 2'(c);
            key(AAKP_KEY_ACK, 4'h0);
            una[c] = 0;
        end
        repeat (2) @(posedge ref_clk);
        chk_cnt();
        chk(sounder, 0);
        blink(1'b0);
        chk(hi, 12);
        chk({led_trouble, led_super, led_pre}, 3'b111);
        // silence, lockout, then toggling
        key(AAKP_KEY_SILENCE, 4'h0);
        repeat (3) @(posedge ref_clk);
        chk({silenceable_on, led_silence, public_notify}, 3'b011);
        key(AAKP_KEY_SILENCE, 4'h0);
        repeat (3) @(posedge ref_clk);
        chk(led_silence, 1);
        repeat (60) @(posedge ref_clk);
        key(AAKP_KEY_SILENCE, 4'h0);
        repeat (3) @(posedge ref_clk);
        chk({silenceable_on, led_silence}, 2'b10);
        repeat (60) @(posedge ref_clk);
        key(AAKP_KEY_SILENCE, 4'h0);
        repeat (3) @(posedge ref_clk);
        chk(led_silence, 1);
        // alarm-off report flashes again until acknowledged
        @(posedge ref_clk);
        alarm_off_rpt <= 1'b1;
        disp_cat <= 2'(AAKP_CAT_ALARM);
        @(posedge ref_clk);
        alarm_off_rpt <= 1'b0;
        blink(1'b0);
        chk(hi > 0 && hi < 12, 1);
        key(AAKP_KEY_ACK, 4'h0);
        key(AAKP_KEY_RESET, 4'h0);
        repeat (3) @(posedge ref_clk);
        bus(1'b0, 8'h04, 32'h0, d);
        chk({d[0], led_alarm}, 2'b11);
        for (int c = 0; c < 4; c++) while (act[c] > 0) ev(c, 1);
        repeat (2) @(posedge ref_clk);
        chk({led_pre, led_trouble}, 2'b00);
        chk({led_super, led_alarm}, 2'b01);
        chk_cnt();
        key(AAKP_KEY_RESET, 4'h0);
        repeat (3) @(posedge ref_clk);
        chk({led_alarm, public_notify, led_silence}, 3'b000);
        bus(1'b0, 8'h04, 32'h0, d);
        chk(d[0], 0);
        // software enables: sounder off with a fresh trouble, then keys off
        bus(1'b1, 8'h00, 32'hffff_fffd, d);
        bus(1'b0, 8'h00, 32'h0, d);
        chk(d, 32'h1);
        ev(2, 0);
        repeat (3) @(posedge ref_clk);
        chk(sounder, 0);
        chk(ocp_n, 2);
        bus(1'b1, 8'h00, 32'h0, d);
        key(AAKP_KEY_SCROLL, 4'h0);
        chk(scroll_step, 0);
        ac_ok_pin <= 1'b0;
        repeat (5) @(posedge ref_clk);
        chk(led_power, 0);
        report_and_stop();
    end
endmodule : aakp_panel_tb_top
`default_nettype wire
